// ===== core/sra_pkg.sv
// constants, types and helper functions of the serial ready and async transmit block
//
// Summary of operation
// (RL1) slave sync mode: ready output low while ready, high while busy.
// (RL2) ready goes low on a trigger write, high on first sync clock fall.
// (RL3) master mode: no ready pin; software polls slave ready on a port.
// (RL4) async character: one start bit, data LSB first, one stop bit.
// (RL5) separate transmit and receive shift registers allow full duplex.
// (RL6) mode bits 0/1 give async 7-bit, 1/1 give async 8-bit.
// (RL7) mode bits 0/0 give sync master, 1/0 give sync slave.
// (RL8) parity enable adds a generated and checked parity bit.
// (RL9) parity select picks odd or even parity for both directions.
// (RL10) pins are general purpose after reset until port select is one.
// (RL11) async mode leaves sync clock and ready pins general purpose.
// (RL12) two source bits pick the serial clock; timer sets its own rate.
// (RL13) software starts the fast oscillator before using it as source.
// (RL14) software holds both enables at zero until transfers begin.
// (RL15) transmit enable zero resets the transmitter; one enables it.
// (RL16) transmit data comes from the byte; 7-bit mode ignores top bit.
// (RL17) trigger starts a low start bit on a shift edge, then a bit per edge.
// (RL18) after the last bit a high stop bit, then line held high.
// (RL19) done flag set when a character ends, interrupt raised if enabled.
// (RL20) software reloads and retriggers per byte, then clears enable.
// (RL21) done flag sets regardless of mask; a one write clears it.
// (RL22) done interrupt asserted only while flag and mask are both one; the code registers it, so it follows a mask change one cycle late.
`default_nettype none

package sra_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned FRAME_W = 11;
  localparam int unsigned CNT_W = 4;

  // mode code is {mode_sel_bit1, mode_sel_bit0}
  localparam logic [1:0] MODE_MASTER = 2'h0;
  localparam logic [1:0] MODE_SLAVE = 2'h1;
  localparam logic [1:0] MODE_ASYNC7 = 2'h2;
  localparam logic [1:0] MODE_ASYNC8 = 2'h3;

  // clock source code is {clock_source_sel1, clock_source_sel0}
  localparam logic [1:0] SRC_OSC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_OSC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_OSC_DIV4 = 2'h2;
  localparam logic [1:0] SRC_TIMER = 2'h3;

  // port 2 pin positions
  localparam int unsigned PIN_SIN = 0;
  localparam int unsigned PIN_SERIAL_OUT_PIN = 1;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_RDY = 3;

  // source ticks per bit, the phases inside a bit, and the bits of a sync character
  localparam logic [CNT_W-1:0] DIV_LAST = 4'hF;
  localparam logic [CNT_W-1:0] DIV_HALF = 4'h7;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [CNT_W-1:0] SYNC_BITS = 4'h8;
  localparam logic [CNT_W-1:0] SYNC_LAST = 4'h7;

  // reset values, and the count at which the receive buffer is full
  localparam logic SERIAL_OUT_PIN_RST = 1'b1;
  localparam logic READY_N_RST = 1'b1;
  localparam logic SCLK_RST = 1'b1;
  localparam logic [3:0] PIN_OE_RST = 4'h0;
  localparam logic [3:0] PIN_OUT_RST = 4'h0;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic {TX_IDLE, TX_BUSY} sra_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} sra_rx_e;

  function automatic logic is_async(input logic [1:0] mode);
    return mode[1];
  endfunction

  // even parity makes the total even; odd select inverts it
  function automatic logic parity_of(input logic [7:0] d, input logic eight, input logic odd);
    return (eight ? (^d) : (^d[6:0])) ^ odd;
  endfunction

  // start bit at bit 0, ones above the stop bit keep the line idle
  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic eight,
                                           input logic pen, input logic odd);
    logic p;
    p = parity_of(d, eight, odd);
    if (eight)
    begin
      return pen ? {1'b1, p, d, 1'b0} : {2'h3, d, 1'b0};
    end
    return pen ? {2'h3, p, d[6:0], 1'b0} : {3'h7, d[6:0], 1'b0};
  endfunction

endpackage

`default_nettype wire

// ===== core/sra_sync.sv
// two flip-flop synchronisers for the serial input and sync clock pins
`timescale 1ns/10ps
`default_nettype none

module sra_sync (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sra_sync_s;

  sra_sync_s sync_reg;
  sra_sync_s sync_next;

  // first stage feeds only the second stage
  always_comb
  begin
    sync_next = sync_reg;
    sync_next.meta = async_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_reg <= '{meta: 2'h3, stable: 2'h3};
    end
    else if (ce)
    begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stable;

endmodule // sra_sync

`default_nettype wire

// ===== core/sra_buf.sv
// two-entry receive data buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module sra_buf (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } sra_buf_s;

  sra_buf_s buf_reg;
  sra_buf_s buf_next;
  logic push;
  logic pop;

  assign in_ready = (buf_reg.cnt != sra_pkg::BUF_FULL);
  assign out_valid = (buf_reg.cnt != 2'h0);
  assign out_data = buf_reg.mem[buf_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    buf_next = buf_reg;
    if (push)
    begin
      buf_next.mem[buf_reg.wr] = in_data;
      buf_next.wr = ~buf_reg.wr;
    end
    if (pop)
    begin
      buf_next.rd = ~buf_reg.rd;
    end
    case ({push, pop})
      2'h2: buf_next.cnt = buf_reg.cnt + 2'h1;
      2'h1: buf_next.cnt = buf_reg.cnt - 2'h1;
      default: buf_next.cnt = buf_reg.cnt;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      buf_reg <= '{mem: 16'h0000, wr: 1'b0, rd: 1'b0, cnt: 2'h0};
    end
    else if (ce)
    begin
      buf_reg <= buf_next;
    end
  end

endmodule // sra_buf

`default_nettype wire

// ===== core/sra_top.sv
// serial interface: sync ready handshake, async transmit, receive paths and pin mux
`timescale 1ns/10ps
`default_nettype none

module sra_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic timer_tick,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic serial_port_select,
  input wire logic mode_sel_bit0,
  input wire logic mode_sel_bit1,
  input wire logic parity_enable_bit,
  input wire logic parity_odd_even_sel,
  input wire logic clock_source_sel0,
  input wire logic clock_source_sel1,
  input wire logic [7:0] tx_rx_data_byte,
  input wire logic tx_trigger,
  input wire logic rx_trigger,
  input wire logic tx_done_clear,
  input wire logic tx_done_mask,
  output logic tx_done_flag,
  output logic tx_done_irq,
  output logic tx_busy,
  output logic ready_out_n,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_overrun,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] port2_in,
  output logic [3:0] port2_out,
  output logic [3:0] port2_oe
);

  typedef struct packed {
    logic [1:0] pre;
    logic [3:0] div;
    sra_pkg::sra_tx_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic serial_out_pin;
    logic done_flag;
    logic irq;
    logic ready_n;
    logic sclk_out;
    logic sclk_prev;
    sra_pkg::sra_rx_e rx_st;
    logic [3:0] rx_div;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_par;
    logic perr;
    logic ferr;
    logic oerr;
    logic push;
    logic [7:0] push_data;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
  } sra_state_s;

  localparam sra_state_s ST_RST = '{
    pre: 2'h0, div: 4'h0, tx_st: sra_pkg::TX_IDLE, tx_sh: 11'h7FF, tx_cnt: 4'h0,
    serial_out_pin: sra_pkg::SERIAL_OUT_PIN_RST, done_flag: 1'b0, irq: 1'b0, ready_n: sra_pkg::READY_N_RST,
    sclk_out: sra_pkg::SCLK_RST, sclk_prev: sra_pkg::SCLK_RST, rx_st: sra_pkg::RX_IDLE,
    rx_div: 4'h0, rx_cnt: 4'h0, rx_sh: 8'h00, rx_par: 1'b0, perr: 1'b0, ferr: 1'b0,
    oerr: 1'b0, push: 1'b0, push_data: 8'h00, pin_out: sra_pkg::PIN_OUT_RST,
    pin_oe: sra_pkg::PIN_OE_RST};

  sra_state_s st_reg;
  sra_state_s st_next;

  // --------------------------------------------------------------------
  // pin synchronisers and receive buffer
  // --------------------------------------------------------------------
  logic [1:0] pins_s;
  logic sin_s;
  logic sclk_s;
  logic buf_in_ready;

  sra_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .async_in({port2_in[sra_pkg::PIN_SCLK], port2_in[sra_pkg::PIN_SIN]}),
    .sync_out(pins_s)
  );

  assign sin_s = pins_s[0];
  assign sclk_s = pins_s[1];

  sra_buf u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .in_valid(st_reg.push),
    .in_ready(buf_in_ready),
    .in_data(st_reg.push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // --------------------------------------------------------------------
  // mode, clock source and shift edges
  // --------------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] src_sel;
  logic async_md;
  logic eight;
  logic is_master;
  logic is_slave;
  logic src_tick;
  logic bit_tick;
  logic sync_act;
  logic m_fall;
  logic m_rise;
  logic s_fall;
  logic s_rise;
  logic e_fall;
  logic e_rise;
  logic shift_ev;
  logic [3:0] dbits;
  logic [3:0] nbits;
  logic done_ev;
  logic tx_go;

  assign mode = {mode_sel_bit1, mode_sel_bit0};
  assign src_sel = {clock_source_sel1, clock_source_sel0};
  assign async_md = sra_pkg::is_async(mode); // RL6
  assign eight = (mode == sra_pkg::MODE_ASYNC8); // RL6
  assign is_master = (mode == sra_pkg::MODE_MASTER); // RL7
  assign is_slave = (mode == sra_pkg::MODE_SLAVE); // RL7

  // timer rate is set on the timer side; this block only counts its ticks
  always_comb
  begin
    case (src_sel) // RL12
      sra_pkg::SRC_OSC_DIV1: src_tick = osc_tick;
      sra_pkg::SRC_OSC_DIV2: src_tick = osc_tick && st_reg.pre[0];
      sra_pkg::SRC_OSC_DIV4: src_tick = osc_tick && (st_reg.pre == sra_pkg::PRE_LAST);
      sra_pkg::SRC_TIMER: src_tick = timer_tick;
      default: src_tick = 1'b0;
    endcase
  end

  assign bit_tick = src_tick && (st_reg.div == sra_pkg::DIV_LAST);
  assign sync_act = (st_reg.tx_st == sra_pkg::TX_BUSY) || (st_reg.rx_st == sra_pkg::RX_SYNC);
  assign m_fall = is_master && sync_act && bit_tick;
  assign m_rise = is_master && sync_act && src_tick && (st_reg.div == sra_pkg::DIV_HALF);
  assign s_fall = st_reg.sclk_prev && !sclk_s;
  assign s_rise = !st_reg.sclk_prev && sclk_s;
  assign e_fall = is_master ? m_fall : (is_slave && s_fall);
  assign e_rise = is_master ? m_rise : (is_slave && s_rise);
  assign shift_ev = async_md ? bit_tick : e_fall; // RL17
  assign dbits = eight ? 4'h8 : 4'h7;
  assign nbits = dbits + {3'h0, parity_enable_bit} + 4'h2; // RL4 RL8
  assign tx_go = tx_trigger && tx_enable_bit && (st_reg.tx_st == sra_pkg::TX_IDLE);
  assign done_ev = (st_reg.tx_st == sra_pkg::TX_BUSY) && tx_enable_bit &&
                   (async_md ? (bit_tick && st_reg.tx_cnt == nbits)
                             : (e_rise && st_reg.tx_cnt == sra_pkg::SYNC_BITS));

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.push = 1'b0;
    st_next.sclk_prev = sclk_s;
    if (osc_tick)
    begin
      st_next.pre = st_reg.pre + 2'h1;
    end
    if (src_tick)
    begin
      st_next.div = st_reg.div + 4'h1;
    end
    if (m_fall)
    begin
      st_next.sclk_out = 1'b0;
    end
    else if (m_rise || !sync_act)
    begin
      st_next.sclk_out = sra_pkg::SCLK_RST;
    end

    // transmitter
    case (st_reg.tx_st)
      sra_pkg::TX_IDLE:
      begin
        if (tx_go)
        begin
          st_next.tx_st = sra_pkg::TX_BUSY;
          st_next.tx_cnt = 4'h0;
          // 7-bit frames drop the top data bit
          st_next.tx_sh = async_md ? sra_pkg::frame_of(tx_rx_data_byte, eight,
                                       parity_enable_bit, parity_odd_even_sel) // RL16 RL8 RL9
                                   : {3'h7, tx_rx_data_byte};
        end
      end
      sra_pkg::TX_BUSY:
      begin
        if (done_ev)
        begin
          st_next.tx_st = sra_pkg::TX_IDLE;
        end
        else if (shift_ev && st_reg.tx_cnt != (async_md ? nbits : sra_pkg::SYNC_BITS))
        begin
          // LSB first; the stop bit comes from the frame and the pin keeps it as the idle level
          st_next.serial_out_pin = st_reg.tx_sh[0]; // RL4 RL17 RL18
          st_next.tx_sh = {1'b1, st_reg.tx_sh[10:1]};
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
        end
      end
      default: st_next.tx_st = sra_pkg::TX_IDLE;
    endcase
    if (!tx_enable_bit)
    begin
      st_next.tx_st = sra_pkg::TX_IDLE; // RL15
      st_next.tx_cnt = 4'h0;
      st_next.serial_out_pin = sra_pkg::SERIAL_OUT_PIN_RST;
    end

    // done flag: a completion in the clearing cycle wins
    if (tx_done_clear)
    begin
      st_next.done_flag = 1'b0; // RL21
    end
    if (done_ev)
    begin
      st_next.done_flag = 1'b1; // RL19 RL21
    end
    st_next.irq = st_next.done_flag && tx_done_mask; // RL22

    // ready handshake, slave mode only
    if (!is_slave)
    begin
      st_next.ready_n = sra_pkg::READY_N_RST;
    end
    else if (s_fall)
    begin
      st_next.ready_n = 1'b1; // RL1 RL2
    end
    else if ((tx_trigger && tx_enable_bit) || (rx_trigger && rx_enable_bit))
    begin
      st_next.ready_n = 1'b0; // RL1 RL2
    end

    // receiver, its own shift register so both directions run at once
    case (st_reg.rx_st) // RL5
      sra_pkg::RX_IDLE:
      begin
        st_next.rx_div = 4'h0;
        st_next.rx_cnt = 4'h0;
        st_next.rx_par = 1'b0;
        if (rx_enable_bit && async_md && !sin_s)
        begin
          st_next.rx_st = sra_pkg::RX_START;
        end
        else if (rx_enable_bit && !async_md && rx_trigger)
        begin
          st_next.rx_st = sra_pkg::RX_SYNC;
        end
      end
      sra_pkg::RX_START:
      begin
        if (src_tick)
        begin
          st_next.rx_div = st_reg.rx_div + 4'h1;
          if (st_reg.rx_div == sra_pkg::DIV_HALF)
          begin
            // a glitch shorter than half a bit is not a start bit
            st_next.rx_st = sin_s ? sra_pkg::RX_IDLE : sra_pkg::RX_DATA;
            st_next.rx_div = 4'h0;
          end
        end
      end
      sra_pkg::RX_DATA:
      begin
        if (src_tick)
        begin
          st_next.rx_div = st_reg.rx_div + 4'h1;
          if (st_reg.rx_div == sra_pkg::DIV_LAST)
          begin
            st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
            if (st_reg.rx_cnt == nbits - 4'h2)
            begin
              st_next.rx_st = sra_pkg::RX_IDLE;
              st_next.push = 1'b1;
              st_next.push_data = eight ? st_reg.rx_sh : {1'b0, st_reg.rx_sh[7:1]};
              st_next.ferr = st_reg.ferr || !sin_s; // RL4
              st_next.perr = st_reg.perr ||
                             (parity_enable_bit && (st_reg.rx_par ^ parity_odd_even_sel)); // RL8 RL9
            end
            else
            begin
              st_next.rx_par = st_reg.rx_par ^ sin_s;
              if (st_reg.rx_cnt < dbits)
              begin
                st_next.rx_sh = {sin_s, st_reg.rx_sh[7:1]};
              end
            end
          end
        end
      end
      sra_pkg::RX_SYNC:
      begin
        if (e_rise)
        begin
          st_next.rx_sh = {sin_s, st_reg.rx_sh[7:1]};
          st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
          if (st_reg.rx_cnt == sra_pkg::SYNC_LAST)
          begin
            st_next.rx_st = sra_pkg::RX_IDLE;
            st_next.push = 1'b1;
            st_next.push_data = {sin_s, st_reg.rx_sh[7:1]};
          end
        end
      end
      default: st_next.rx_st = sra_pkg::RX_IDLE;
    endcase
    if (st_reg.push && !buf_in_ready)
    begin
      st_next.oerr = 1'b1;
    end
    // disabling the receiver also clears its error flags
    if (!rx_enable_bit)
    begin
      st_next.rx_st = sra_pkg::RX_IDLE;
      st_next.push = 1'b0;
      st_next.perr = 1'b0;
      st_next.ferr = 1'b0;
      st_next.oerr = 1'b0;
    end

    // pin mux; registering it costs one cycle of latency on the general purpose pins, serial pins take next-state values
    st_next.pin_out = gpio_out; // RL10
    st_next.pin_oe = gpio_oe; // RL10 RL11
    if (serial_port_select)
    begin
      st_next.pin_oe[sra_pkg::PIN_SIN] = 1'b0;
      st_next.pin_out[sra_pkg::PIN_SIN] = 1'b0;
      st_next.pin_oe[sra_pkg::PIN_SERIAL_OUT_PIN] = 1'b1;
      st_next.pin_out[sra_pkg::PIN_SERIAL_OUT_PIN] = st_next.serial_out_pin;
      if (is_master)
      begin
        st_next.pin_oe[sra_pkg::PIN_SCLK] = 1'b1;
        st_next.pin_out[sra_pkg::PIN_SCLK] = st_next.sclk_out;
      end
      else if (is_slave)
      begin
        st_next.pin_oe[sra_pkg::PIN_SCLK] = 1'b0;
        st_next.pin_out[sra_pkg::PIN_SCLK] = 1'b0;
        st_next.pin_oe[sra_pkg::PIN_RDY] = 1'b1;
        st_next.pin_out[sra_pkg::PIN_RDY] = st_next.ready_n; // RL1
      end
      // async and master leave the remaining pins to the port logic
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_reg <= ST_RST;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign tx_done_flag = st_reg.done_flag;
  assign tx_done_irq = st_reg.irq;
  assign tx_busy = (st_reg.tx_st == sra_pkg::TX_BUSY);
  assign ready_out_n = st_reg.ready_n;
  assign rx_parity_err = st_reg.perr;
  assign rx_frame_err = st_reg.ferr;
  assign rx_overrun = st_reg.oerr;
  assign port2_out = st_reg.pin_out;
  assign port2_oe = st_reg.pin_oe;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !ce);

  chk_ready_on_trig: assert property ( // RL2
    is_slave && tx_trigger && tx_enable_bit && !s_fall |=> !ready_out_n)
    else $error("ready did not fall after trigger");
  chk_ready_on_fall: assert property ( // RL1
    is_slave && s_fall |=> ready_out_n)
    else $error("ready did not rise on sync clock fall");
  chk_ready_idle_master: assert property ( // RL7
    !is_slave |=> ready_out_n)
    else $error("ready driven low outside slave mode");
  chk_start_bit_low: assert property ( // RL17
    async_md && tx_busy && tx_enable_bit && st_reg.tx_cnt == 4'h0 && bit_tick |=> !st_reg.serial_out_pin)
    else $error("start bit not low");
  chk_stop_bit_high: assert property ( // RL18
    async_md && tx_busy && tx_enable_bit && bit_tick && st_reg.tx_cnt == nbits - 4'h1
    |=> st_reg.serial_out_pin ##1 st_reg.serial_out_pin)
    else $error("stop bit not high");
  chk_done_sets: assert property ( // RL19
    done_ev |=> tx_done_flag && !tx_busy)
    else $error("done flag not set at end of character");
  chk_done_clears: assert property ( // RL21
    tx_done_clear && !done_ev |=> !tx_done_flag)
    else $error("done flag not cleared");
  chk_irq_gate: assert property ( // RL22
    ##1 (tx_done_irq == (tx_done_flag && $past(tx_done_mask))))
    else $error("interrupt not equal to flag and mask");
  chk_tx_enable_bit_resets: assert property ( // RL15
    !tx_enable_bit |=> !tx_busy && st_reg.serial_out_pin)
    else $error("transmitter not reset by enable low");
  chk_gpio_default: assert property ( // RL10
    !serial_port_select |=> port2_oe == $past(gpio_oe) && port2_out == $past(gpio_out))
    else $error("pins not general purpose while port select low");
  chk_async_free_pins: assert property ( // RL11
    serial_port_select && async_md |=> port2_oe[3:2] == $past(gpio_oe[3:2]))
    else $error("async mode took clock or ready pin");

  cov_async_done: cover property (async_md && done_ev);
  cov_slave_done: cover property (is_slave && done_ev);
  cov_rx_push: cover property (async_md && st_reg.push);
  cov_overrun: cover property (st_reg.push && !buf_in_ready);

endmodule // sra_top

`default_nettype wire

// ===== dv/sra_peer.sv
// far-side serial device model: async catcher, async sender, sync clock
`timescale 1ns/10ps
`default_nettype none

module sra_peer (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out,
  output logic sclk
);
  // ----
  // line model
  // ----
  // catcher takes its bit time in clk_sys cycles; sender always uses 16
  initial
  begin
    line_out = 1'b1;
    sclk = 1'b1;
  end

  task automatic catch_frame(input int n, input int per, output logic [10:0] f);
    f = '1;
    @(negedge line_in);
    repeat (per / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      f[i] = line_in;
      repeat (per) @(posedge clk_sys);
    end
  endtask

  // released line idles high, as the pull-up would hold it
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      line_out = f[i];
      repeat (15) @(negedge clk_sys);
    end
  endtask

  // one sync clock period of 160 ns, standing high outside it
  task automatic sclk_pulse();
    sclk = 1'b0;
    #80;
    sclk = 1'b1;
    #80;
  endtask
endmodule // sra_peer

`default_nettype wire

// ===== dv/sra_top_bench.sv
// self-checking bench of the serial ready and async transmit block
`timescale 1ns/10ps
`default_nettype none

module sra_top_bench;
  logic clk_sys, reset, ce, osc_tick, timer_tick, tx_enable_bit, rx_enable_bit;
  logic serial_port_select, mode_sel_bit0, mode_sel_bit1, parity_enable_bit;
  logic parity_odd_even_sel, clock_source_sel0, clock_source_sel1, tx_trigger, rx_trigger;
  logic tx_done_clear, tx_done_mask, tx_done_flag, tx_done_irq, tx_busy, ready_out_n;
  logic rx_valid, rx_ready, rx_parity_err, rx_frame_err, rx_overrun, sin_line, sclk_line;
  logic [7:0] tx_rx_data_byte, rx_data;
  logic [3:0] gpio_out, gpio_oe, port2_in, port2_out, port2_oe;
  logic [10:0] got;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  // ----
  // wiring
  // ----
  // undriven ready and serial output pins read high through the pull-up; an undriven clock pin reads the peer's sync clock
  assign port2_in = {port2_oe[3] ? port2_out[3] : 1'b1, port2_oe[2] ? port2_out[2] : sclk_line,
                     port2_oe[1] ? port2_out[1] : 1'b1, sin_line};

  sra_peer u_peer (.clk_sys, .line_in(port2_in[1]), .line_out(sin_line), .sclk(sclk_line));

  sra_top u_dut (.clk_sys, .reset, .ce, .osc_tick, .timer_tick, .tx_enable_bit,
    .rx_enable_bit, .serial_port_select, .mode_sel_bit0, .mode_sel_bit1, .parity_enable_bit,
    .parity_odd_even_sel, .clock_source_sel0, .clock_source_sel1, .tx_rx_data_byte,
    .tx_trigger, .rx_trigger, .tx_done_clear, .tx_done_mask, .tx_done_flag, .tx_done_irq,
    .tx_busy, .ready_out_n, .rx_data, .rx_valid, .rx_ready, .rx_parity_err, .rx_frame_err,
    .rx_overrun, .gpio_out, .gpio_oe, .port2_in, .port2_out, .port2_oe);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // start at bit 0, ones above the stop bit
  function automatic logic [10:0] frm(logic [7:0] d, logic e8, logic pe, logic od);
    logic [10:0] f;
    f = {2'h3, d & {e8, 7'h7F}, 1'b0};
    if (!e8)
      f[8] = 1'b1;
    if (pe)
      f[e8 ? 9 : 8] = (^(d & {e8, 7'h7F})) ^ od;
    return f;
  endfunction

  task automatic tx_go(input logic [7:0] d);
    @(negedge clk_sys);
    tx_rx_data_byte = d;
    tx_trigger = 1'b1;
    @(negedge clk_sys);
    tx_trigger = 1'b0;
  endtask

  task automatic tx_one(input logic [7:0] d);
    int per;
    // sixteen source ticks a bit; the bench ticks the selected source every cycle
    per = (clock_source_sel1 ^ clock_source_sel0) ? (clock_source_sel1 ? 64 : 32) : 16;
    fork
      u_peer.catch_frame(9 + mode_sel_bit0 + parity_enable_bit, per, got);
      tx_go(d);
    join
    // the catcher ends on a rising edge; inputs only move on falling ones
    @(negedge clk_sys);
    for (int k = 0; k < 40 && tx_done_flag !== 1'b1; k++)
      @(negedge clk_sys);
    chk("frame", got, frm(d, mode_sel_bit0, parity_enable_bit, parity_odd_even_sel));
    chk("done flag", tx_done_flag, 11'h1);
    chk("done irq", tx_done_irq, tx_done_mask);
    tx_done_clear = 1'b1;
    @(negedge clk_sys);
    tx_done_clear = 1'b0;
    @(negedge clk_sys);
    chk("flag clear", tx_done_flag, 11'h0);
  endtask

  // ----
  // sequence
  // ----
  initial
  begin
    {reset, ce, osc_tick} = 3'h7;
    gpio_out = 4'hA;
    gpio_oe = 4'hC;
    tx_rx_data_byte = 8'h00;
    {tx_enable_bit, rx_enable_bit, serial_port_select, mode_sel_bit0, mode_sel_bit1,
     parity_enable_bit, parity_odd_even_sel, clock_source_sel0, clock_source_sel1, tx_trigger,
     rx_trigger, tx_done_clear, tx_done_mask, rx_ready, timer_tick} = '0;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("ready idle", ready_out_n, 11'h1);
    chk("gpio pins", {port2_oe, port2_out}, 8'hCA);
    tx_go(8'h55);
    repeat (3) @(negedge clk_sys);
    chk("busy off", tx_busy, 11'h0);
    {serial_port_select, mode_sel_bit1, tx_enable_bit, rx_enable_bit} = 4'hF;
    repeat (3) @(negedge clk_sys);
    chk("serial oe", port2_oe[3:1], 3'h7);
    chk("gpio kept", port2_out[3:2], 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      // the timer case starves the oscillator, so a wrong source hangs
      {mode_sel_bit0, tx_done_mask} = {2{i[0]}};
      {clock_source_sel1, clock_source_sel0} = 2'(i);
      {parity_enable_bit, timer_tick} = {2{i[1]}};
      osc_tick = (i != 3);
      parity_odd_even_sel = i[0] ^ i[1];
      tx_one(8'hC3 ^ 8'(i * 8'h45));
    end
    {osc_tick, timer_tick, clock_source_sel0, clock_source_sel1, parity_enable_bit} = 5'h10;
    fork
      tx_one(8'h96);
      for (int j = 0; j < 3; j++)
        u_peer.send_byte(8'h30 + 8'(j));
    join
    repeat (20) @(negedge clk_sys);
    chk("rx head", {rx_valid, rx_data}, 11'h130);
    chk("overrun", rx_overrun, 11'h1);
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
    chk("rx next", rx_data, 8'h31);
    chk("rx errs", {rx_parity_err, rx_frame_err}, 11'h0);
    // async7 with even parity: bit 7 of the sent byte lands in the parity slot
    {mode_sel_bit0, parity_enable_bit} = 2'h1;
    u_peer.send_byte(8'h01);
    repeat (4) @(negedge clk_sys);
    chk("parity err", {rx_parity_err, rx_frame_err}, 11'h2);
    // without parity the same low bit 7 lands in the stop slot
    parity_enable_bit = 1'b0;
    u_peer.send_byte(8'h01);
    repeat (4) @(negedge clk_sys);
    chk("frame err", rx_frame_err, 11'h1);
    {mode_sel_bit0, mode_sel_bit1} = 2'h2;
    tx_go(8'h0F);
    @(negedge clk_sys);
    chk("ready low", {ready_out_n, port2_oe[3], port2_out[3]}, 3'h2);
    u_peer.sclk_pulse();
    repeat (2) @(negedge clk_sys);
    chk("ready back", {ready_out_n, tx_busy}, 11'h3);
    tx_enable_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("abort", tx_busy, 11'h0);
    rx_trigger = 1'b1;
    @(negedge clk_sys);
    rx_trigger = 1'b0;
    chk("ready rx", ready_out_n, 11'h0);
    {mode_sel_bit0, tx_enable_bit} = 2'h1;
    gpio_out = 4'h2;
    tx_go(8'hF0);
    repeat (3) @(negedge clk_sys);
    chk("master", {ready_out_n, port2_oe[2], tx_busy, port2_out[3]}, 11'hE);
    tx_enable_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("master stop", tx_busy, 11'h0);
    give_verdict();
  end
endmodule // sra_top_bench

`default_nettype wire
